// ---- hdl/guard_pkg.sv ----
// Shared constants and types for the guard sensor touch-state block
package guard_pkg;

    // ------------------------------------------------------------
    // Tuning defaults and ranges
    // ------------------------------------------------------------
    localparam logic [7:0] FINGER_TH_RST = 8'h64;   // 100 counts
    localparam logic [7:0] NOISE_TH_RST  = 8'h14;   // 20 counts
    localparam logic [7:0] HYST_RST      = 8'h0A;   // 10 counts
    localparam logic [7:0] DEBOUNCE_RST  = 8'h05;   // 5 samples
    localparam logic [7:0] TUNE_MIN      = 8'h01;   // Zero is refused
    localparam logic [8:0] SUM_MAX       = 9'h0FE;  // Threshold plus hyst

    // ------------------------------------------------------------
    // Resolution, current source and sensitivity
    // ------------------------------------------------------------
    localparam logic [4:0] RES_RST       = 5'h0A;   // 10 bits
    localparam logic [4:0] RES_MIN       = 5'h08;   // Narrowest scan
    localparam logic [7:0] DAC_RST       = 8'hC8;   // 200
    localparam logic [2:0] SENS_RST      = 3'h2;    // 0.2 pF
    localparam logic [2:0] SENS_MIN      = 3'h1;    // 0.1 pF
    localparam logic [2:0] SENS_MAX      = 3'h4;    // 0.4 pF

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SENSE_IDLE  = 2'b01,                        // Inactive
        SENSE_GUARD = 2'b10                         // Active, others blocked
    } sense_state_t;

    typedef enum logic [1:0]
    {
        SCAN_NONE    = 2'h0,
        SCAN_NORMAL  = 2'h1,                        // One slot of the sequence
        SCAN_PROX    = 2'h2,                        // Proximity group
        SCAN_GENERIC = 2'h3                         // Generic group
    } scan_cmd_t;

endpackage

// ---- hdl/guard_debounce.sv ----
// Consecutive-sample debounce counter for the inactive-to-active move
`timescale 1ns/1ps
module guard_debounce
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Sample strobe while inactive, and its comparison result
    input  wire logic       step,
    input  wire logic       above,
    input  wire logic [7:0] limit,
    // Result
    output logic            reached,
    output logic [7:0]      count
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [7:0] count_reg;                          // Samples above so far

    // Counts consecutive samples above; any miss restarts from zero
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            count_reg <= 8'h00;
        else if (step && above && !reached)
            count_reg <= count_reg + 8'h01;         // RQ7
        else if (step)
            count_reg <= 8'h00;                     // RQ15
    end

    // Done once this sample brings the run up to the limit
    assign reached = above && ({1'b0, count_reg} + 9'h001 >= {1'b0, limit});
    assign count   = count_reg;

endmodule // guard_debounce

// ---- hdl/guard_sensor_touch_state.sv ----
// Guard sensor touch state, baseline tracking and scan-slot control
// Functional notes
// RQ1: Guard never reports press; activity blocks widgets
// RQ2: Touched when scan value exceeds finger threshold
// RQ3: Host keeps threshold plus hysteresis within 254
// RQ4: Counts above noise threshold never update baseline
// RQ5: Inactive needs difference above threshold plus hysteresis
// RQ6: Active releases below threshold minus hysteresis
// RQ7: Activation needs debounce consecutive samples above
// RQ8: Raw count limited to two-power-N minus one
// RQ9: Proximity only scanned on explicit start
// RQ10: Current-source DAC setting applies only when selected
// RQ11: Sensitivity codes 1..4 map to 0.1..0.4 pF
// RQ12: Multi-member proximity/generic sensors scanned together
// RQ13: All widget elements share one scan channel
// RQ14: Difference is raw minus baseline, floored zero
// RQ15: Inactive miss clears debounce counter
`timescale 1ns/1ps
module guard_sensor_touch_state
#(
    parameter int COUNT_W  = 16,                    // Raw count width
    parameter int N_SENS   = 8,                     // Physical sensors
    parameter int N_WIDGET = 4                      // Widgets for channels
)
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // Scan samples
    input  wire logic                 sample_valid,
    input  wire logic [COUNT_W-1:0]   raw_count,
    // Tuning load
    input  wire logic                 tune_load,
    input  wire logic [7:0]           finger_th_in,
    input  wire logic [7:0]           noise_th_in,
    input  wire logic [7:0]           hyst_in,
    input  wire logic [7:0]           debounce_in,
    input  wire logic [4:0]           resolution_in,
    // Current source and sensitivity
    input  wire logic                 dac_load,
    input  wire logic [7:0]           dac_in,
    input  wire logic                 dac_selected,
    input  wire logic                 sens_load,
    input  wire logic [2:0]           sens_in,
    input  wire logic                 auto_tuning,
    // Scan slot control
    input  wire logic                 scan_go,
    input  wire logic [1:0]           scan_cmd,
    input  wire logic [$clog2(N_SENS)-1:0] scan_slot,
    input  wire logic [N_SENS-1:0]    prox_mask,
    input  wire logic [N_SENS-1:0]    generic_mask,
    input  wire logic                 scan_end,
    input  wire logic                 move_widget,
    input  wire logic [$clog2(N_WIDGET)-1:0] widget_idx,
    // Results
    output logic                      finger_press,
    output logic                      guard_invalid,
    output logic [COUNT_W-1:0]        count_out,
    output logic [COUNT_W-1:0]        baseline_out,
    output logic [COUNT_W-1:0]        diff_out,
    output logic [7:0]                dac_out,
    output logic [2:0]                sens_tenth_pf,
    output logic [N_SENS-1:0]         connect_mask,
    output logic [N_WIDGET-1:0]       widget_channel
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (COUNT_W < 9 || COUNT_W > 31)
        $error("COUNT_W must lie in 9..31");
    if (N_SENS < 2 || N_WIDGET < 2)
        $error("N_SENS and N_WIDGET must be at least 2");

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_b;                               // First stage
    logic rst_sync_b;                               // Used everywhere

    // Release is synchronised so no flop sees a partial release
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ------------------------------------------------------------
    // Tuning registers
    // ------------------------------------------------------------
    logic [7:0] finger_th_reg;                      // Finger threshold
    logic [7:0] noise_th_reg;                       // Noise threshold
    logic [7:0] hyst_reg;                           // Hysteresis
    logic [7:0] debounce_reg;                       // Debounce samples
    logic [4:0] res_reg;                            // Scan resolution

    // Zero or out-of-range fields are refused and the old value kept
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            finger_th_reg <= guard_pkg::FINGER_TH_RST;  // RQ2
            noise_th_reg  <= guard_pkg::NOISE_TH_RST;   // RQ4
            hyst_reg      <= guard_pkg::HYST_RST;       // RQ5
            debounce_reg  <= guard_pkg::DEBOUNCE_RST;   // RQ7
            res_reg       <= guard_pkg::RES_RST;        // RQ8
        end
        else if (tune_load)
        begin
            if (finger_th_in >= guard_pkg::TUNE_MIN)
                finger_th_reg <= finger_th_in;
            if (noise_th_in >= guard_pkg::TUNE_MIN)
                noise_th_reg <= noise_th_in;
            if (hyst_in >= guard_pkg::TUNE_MIN)
                hyst_reg <= hyst_in;
            if (debounce_in >= guard_pkg::TUNE_MIN)
                debounce_reg <= debounce_in;
            if (resolution_in >= guard_pkg::RES_MIN &&
                32'(resolution_in) <= COUNT_W)
                res_reg <= resolution_in;
        end
    end

    // ------------------------------------------------------------
    // Count conditioning
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] max_count;                  // Two-power-N minus one
    logic [COUNT_W-1:0] raw_lim;                    // Limited raw count
    logic [COUNT_W-1:0] baseline_reg;               // Tracked baseline
    logic [COUNT_W-1:0] diff;                       // Difference count
    logic [8:0]         on_level;                   // Threshold plus hyst
    logic [8:0]         off_level;                  // Threshold minus hyst
    logic               above_on;                   // Activation candidate
    logic               below_off;                  // Release condition

    assign max_count = {COUNT_W{1'b1}} >> (COUNT_W - 32'(res_reg));
    assign raw_lim   = (raw_count > max_count) ? max_count : raw_count; // RQ8
    assign diff      = (raw_lim > baseline_reg) ?
                       raw_lim - baseline_reg : '0;            // RQ14
    // Sum fits nine bits; the host keeps it within 254 anyway
    assign on_level  = {1'b0, finger_th_reg} + {1'b0, hyst_reg};  // RQ3
    assign off_level = (finger_th_reg > hyst_reg) ?
                       {1'b0, finger_th_reg - hyst_reg} : 9'h000;
    assign above_on  = diff > COUNT_W'(on_level);              // RQ5
    assign below_off = diff < COUNT_W'(off_level);             // RQ6

    // Baseline follows quiet samples only, so a finger never raises it
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            baseline_reg <= '0;
        else if (sample_valid && diff <= COUNT_W'(noise_th_reg))
            baseline_reg <= raw_lim;                           // RQ4
    end

    // Sample results held for the reader
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            count_out <= '0;
            diff_out  <= '0;
        end
        else if (sample_valid)
        begin
            count_out <= raw_lim;                              // RQ8
            diff_out  <= diff;                                 // RQ14
        end
    end
    assign baseline_out = baseline_reg;

    // ------------------------------------------------------------
    // Touch state
    // ------------------------------------------------------------
    guard_pkg::sense_state_t state_reg;             // Guard state
    logic                    deb_reached;           // Run long enough
    logic [7:0]              deb_count;             // Current run
    logic                    idle_step;             // Sample while idle

    assign idle_step = sample_valid && (state_reg == guard_pkg::SENSE_IDLE);

    guard_debounce u_debounce
    (
        .clock   (clock),
        .rst_b   (rst_sync_b),
        .step    (idle_step),
        .above   (above_on),
        .limit   (debounce_reg),
        .reached (deb_reached),
        .count   (deb_count)
    );

    // Two-state machine; activity means exceeding the finger threshold plus hysteresis
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            state_reg <= guard_pkg::SENSE_IDLE;
        else
            case (state_reg)
                guard_pkg::SENSE_IDLE:
                    if (idle_step && deb_reached)
                        state_reg <= guard_pkg::SENSE_GUARD;   // RQ2
                guard_pkg::SENSE_GUARD:
                    if (sample_valid && below_off)
                        state_reg <= guard_pkg::SENSE_IDLE;    // RQ6
                default:
                    state_reg <= guard_pkg::SENSE_IDLE;
            endcase
    end

    // Guard raises only the invalid flag; the press flop stays clear
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            finger_press  <= 1'b0;
            guard_invalid <= 1'b0;
        end
        else
        begin
            finger_press  <= 1'b0;                             // RQ1
            guard_invalid <= (state_reg == guard_pkg::SENSE_GUARD); // RQ1
        end
    end

    // ------------------------------------------------------------
    // Current source and sensitivity
    // ------------------------------------------------------------
    logic [7:0] dac_reg;                            // DAC setting
    logic [2:0] sens_reg;                           // Sensitivity code

    // Codes outside 1..4 are ignored
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            dac_reg  <= guard_pkg::DAC_RST;                    // RQ10
            sens_reg <= guard_pkg::SENS_RST;                   // RQ11
        end
        else
        begin
            if (dac_load)
                dac_reg <= dac_in;
            if (sens_load && sens_in >= guard_pkg::SENS_MIN &&
                sens_in <= guard_pkg::SENS_MAX)
                sens_reg <= sens_in;
        end
    end

    // Settings reach the front end only in their own mode
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            dac_out       <= 8'h00;
            sens_tenth_pf <= 3'h0;
        end
        else
        begin
            dac_out       <= dac_selected ? dac_reg : 8'h00;   // RQ10
            sens_tenth_pf <= auto_tuning ? sens_reg : 3'h0;    // RQ11
        end
    end

    // ------------------------------------------------------------
    // Scan slots and channels
    // ------------------------------------------------------------
    logic [N_SENS-1:0] slot_hot;                    // Slot as one-hot

    assign slot_hot = N_SENS'(1) << scan_slot;

    // A group connects all its members at once for one measurement
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            connect_mask <= '0;
        else if (scan_go)
            case (scan_cmd)
                guard_pkg::SCAN_NORMAL:
                    connect_mask <= slot_hot & ~prox_mask;     // RQ9
                guard_pkg::SCAN_PROX:
                    connect_mask <= prox_mask;                 // RQ12
                guard_pkg::SCAN_GENERIC:
                    connect_mask <= generic_mask;              // RQ12
                default:
                    connect_mask <= '0;
            endcase
        else if (scan_end)
            connect_mask <= '0;
    end

    // One bit per widget, so its elements cannot be split
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            widget_channel <= '0;
        else if (move_widget)
            widget_channel[widget_idx] <= ~widget_channel[widget_idx]; // RQ13
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_sync_b);

    sequence seq_idle_hit;
        idle_step && above_on;
    endsequence

    sequence seq_idle_miss;
        idle_step && !above_on;
    endsequence

    a_no_press_report: assert property (##1 !finger_press) // RQ1
        else $error("guard reported a finger press");
    a_invalid_tracks: assert property (
        (state_reg == guard_pkg::SENSE_GUARD) |=> guard_invalid) // RQ1
        else $error("invalid flag missing while guard active");
    a_activate_cause: assert property (
        $rose(state_reg == guard_pkg::SENSE_GUARD) |->
        $past(idle_step && above_on && deb_reached)) // RQ7
        else $error("activation without sample above level");
    // Each hit short of the limit lengthens the run by exactly one
    a_run_counts: assert property (seq_idle_hit ##0 !deb_reached |=> // RQ7
        deb_count == $past(deb_count) + 8'h01)
        else $error("debounce run not counted");
    a_miss_clears: assert property (seq_idle_miss |=> deb_count == 8'h00) // RQ15
        else $error("debounce counter not cleared");
    a_release_below: assert property (
        (state_reg == guard_pkg::SENSE_GUARD) && sample_valid && below_off
        |=> state_reg == guard_pkg::SENSE_IDLE) // RQ6
        else $error("guard did not release");
    a_hold_active: assert property (
        (state_reg == guard_pkg::SENSE_GUARD) && sample_valid && !below_off
        |=> state_reg == guard_pkg::SENSE_GUARD) // RQ6
        else $error("guard released too early");
    a_baseline_noise: assert property (
        sample_valid && diff > COUNT_W'(noise_th_reg)
        |=> $stable(baseline_reg)) // RQ4
        else $error("baseline moved on noisy sample");
    a_raw_limit: assert property (
        sample_valid |=> count_out <= $past(max_count)) // RQ8
        else $error("count exceeds resolution");
    a_prox_excluded: assert property (
        scan_go && scan_cmd == guard_pkg::SCAN_NORMAL
        |=> (connect_mask & $past(prox_mask)) == '0) // RQ9
        else $error("proximity sensor in normal scan");
    a_group_connect: assert property (
        scan_go && scan_cmd == guard_pkg::SCAN_PROX
        |=> connect_mask == $past(prox_mask)) // RQ12
        else $error("proximity members not connected together");
    a_dac_gate: assert property (
        !dac_selected |=> dac_out == 8'h00) // RQ10
        else $error("DAC value applied while not selected");
    a_sens_gate: assert property (
        auto_tuning |=> sens_tenth_pf >= guard_pkg::SENS_MIN &&
        sens_tenth_pf <= guard_pkg::SENS_MAX) // RQ11
        else $error("sensitivity out of range");
    a_channel_move: assert property (
        move_widget |=> widget_channel[$past(widget_idx)] !=
        $past(widget_channel[widget_idx])) // RQ13
        else $error("widget channel not moved");

endmodule // guard_sensor_touch_state

// ---- tb/sense_front.sv ----
// Behavioural scan front end that hands raw counts to the block
`timescale 1ns/1ps
module sense_front
(
    // Clock
    input  wire logic        clock,
    // Conversion request from the bench
    input  wire logic        go,
    input  wire logic [15:0] value,
    input  wire logic [3:0]  gap,
    // Result towards the block
    output logic             sample_valid,
    output logic [15:0]      raw_count
);
    logic        busy_reg = 1'b0;   // Conversion under way
    logic [3:0]  wait_reg = 4'h0;   // Cycles left before the result
    logic [15:0] hold_reg = 16'h0;  // Count being converted

    // --------------------------------------------------------------
    // Conversion timing
    // --------------------------------------------------------------
    // Outside a result the count bus toggles, so a block that reads
    // it without the strobe sees garbage rather than a stale value
    initial sample_valid = 1'b0;
    initial raw_count = 16'h5A5A;
    always @(posedge clock)
    begin
        sample_valid <= 1'b0;
        raw_count    <= ~raw_count;
        if (go)
        begin
            busy_reg <= 1'b1;
            wait_reg <= gap;
            hold_reg <= value;
        end
        else if (busy_reg && wait_reg == 4'h0)
        begin
            busy_reg     <= 1'b0;
            sample_valid <= 1'b1;
            raw_count    <= hold_reg;
        end
        else if (busy_reg)
            wait_reg <= wait_reg - 4'h1;
    end
endmodule // sense_front

// ---- tb/tb_top.sv ----
// Self-checking bench for the guard sensor touch-state block
`timescale 1ns/1ps
module tb_top;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic clock = 1'b0, rst_b = 1'b0, go = 1'b0;
    logic [15:0] value = 16'h0;
    logic [3:0]  gap = 4'h0;
    logic sample_valid, tune_load = 0, dac_load = 0, dac_selected = 0;
    logic sens_load = 0, auto_tuning = 0, scan_go = 0, scan_end = 0;
    logic move_widget = 0;
    logic [15:0] raw_count, count_out, baseline_out, diff_out;
    logic [7:0]  finger_th_in = 0, noise_th_in = 0, hyst_in = 0;
    logic [7:0]  debounce_in = 0, dac_in = 0, dac_out;
    logic [7:0]  prox_mask = 8'h30, generic_mask = 8'h0C, connect_mask;
    logic [4:0]  resolution_in = 0;
    logic [2:0]  sens_in = 0, sens_tenth_pf, scan_slot = 0;
    logic [1:0]  scan_cmd = 0, widget_idx = 0;
    logic [3:0]  widget_channel;
    logic finger_press, guard_invalid;
    int err_total = 0, num_checks = 0;

    always #12.5 clock = ~clock;  // 40 MHz

    // --------------------------------------------------------------
    // Block and its front end
    // --------------------------------------------------------------
    sense_front sense_front_i (.clock(clock), .go(go), .value(value),
        .gap(gap), .sample_valid(sample_valid), .raw_count(raw_count));
    guard_sensor_touch_state #(.COUNT_W(16), .N_SENS(8), .N_WIDGET(4))
    guard_sensor_touch_state_i (.clock(clock), .rst_b(rst_b),
        .sample_valid(sample_valid), .raw_count(raw_count),
        .tune_load(tune_load), .finger_th_in(finger_th_in),
        .noise_th_in(noise_th_in), .hyst_in(hyst_in),
        .debounce_in(debounce_in), .resolution_in(resolution_in),
        .dac_load(dac_load), .dac_in(dac_in), .dac_selected(dac_selected),
        .sens_load(sens_load), .sens_in(sens_in), .auto_tuning(auto_tuning),
        .scan_go(scan_go), .scan_cmd(scan_cmd), .scan_slot(scan_slot),
        .prox_mask(prox_mask), .generic_mask(generic_mask),
        .scan_end(scan_end), .move_widget(move_widget),
        .widget_idx(widget_idx), .finger_press(finger_press),
        .guard_invalid(guard_invalid), .count_out(count_out),
        .baseline_out(baseline_out), .diff_out(diff_out),
        .dac_out(dac_out), .sens_tenth_pf(sens_tenth_pf),
        .connect_mask(connect_mask), .widget_channel(widget_channel));

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    // Inputs always move 2 ns after the rising edge
    task tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp,
               input string what);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s %h not %h", $time, what,
                     seen, exp);
        end
    endtask

    // One conversion; waits long enough for the delayed state output
    task sample(input logic [15:0] v, input logic [3:0] g);
        int n;
        value = v;
        gap = g;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        n = 0;
        while (sample_valid !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        if (n == 40)
            check(1'b0, 1'b1, "no sample");
        tick(4);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    // Debounce with a miss, then release at the exact boundary
    task touch_cycle;
        sample(16'd10, 4'h0);                 // Seeds baseline 10
        check(baseline_out, 16'd10, "seed");
        for (int i = 0; i < 10; i++)
        begin
            // Fifth sample is one count short, so the run restarts
            sample(i == 4 ? 16'd120 : 16'd121, i[3:0]);
            check(guard_invalid, i == 9, "activate");
            check(finger_press, 1'b0, "press");
        end
        check(diff_out, 16'd111, "diff");
        check(baseline_out, 16'd10, "no track");
        sample(16'd100, 4'h2);                          // Diff 90
        check(guard_invalid, 1'b1, "hold");
        sample(16'd99, 4'h0);                           // Diff 89
        check(guard_invalid, 1'b0, "release");
        sample(16'd5, 4'h0);
        check(diff_out, 16'd0, "floor");
        sample(16'd25, 4'h0);                           // Diff 20
        check(baseline_out, 16'd25, "noise edge");
        sample(16'd46, 4'h0);                           // Diff 21
        check(baseline_out, 16'd25, "noise over");
    endtask

    // Resolution limit, an out-of-range width left unused
    task resolution;
        resolution_in = 5'h08;
        tune_load = 1'b1;                     // Zero fields keep old
        tick(1);
        tune_load = 1'b0;
        sample(16'h03FF, 4'h0);
        check(count_out, 16'h00FF, "8 bit");
        resolution_in = 5'h14;
        tune_load = 1'b1;
        tick(1);
        tune_load = 1'b0;
        sample(16'h01FF, 4'h0);
        check(count_out, 16'h00FF, "kept 8");
        resolution_in = 5'h0A;
        tune_load = 1'b1;                      // Sum stays 110
        tick(1);
        tune_load = 1'b0;
        sample(16'hFFFF, 4'h0);
        check(count_out, 16'h03FF, "10 bit");
        sample(16'd25, 4'h0);                  // Clears the run
    endtask

    // Current source and sensitivity settings
    task settings;
        check(dac_out, 16'h0, "dac off");
        dac_selected = 1'b1;
        tick(2);
        check(dac_out, 16'h00C8, "dac rst");
        check(sens_tenth_pf, 16'h0, "sens off");
        auto_tuning = 1'b1;
        tick(2);
        check(sens_tenth_pf, 16'h2, "sens rst");
        for (int c = 0; c < 6; c++)
        begin
            sens_in = c[2:0];
            sens_load = 1'b1;
            tick(1);
            sens_load = 1'b0;
            tick(2);
            // Codes 0 and 5 are refused and keep the last good one
            check(sens_tenth_pf, c == 0 ? 2 : c > 4 ? 4 : c, "sens");
        end
        dac_in = 8'h00;
        dac_load = 1'b1;
        tick(1);
        dac_load = 1'b0;
        tick(2);
        check(dac_out, 16'h0, "dac zero");
    endtask

    // Scan slots, proximity start and widget channel moves
    task scans;
        logic [1:0] cmds [4] = '{2'h2, 2'h3, 2'h1, 2'h1};
        logic [2:0] slots [4] = '{3'h0, 3'h0, 3'h5, 3'h2};
        logic [7:0] exps [4] = '{8'h30, 8'h0C, 8'h00, 8'h04};
        for (int i = 0; i < 4; i++)
        begin
            scan_cmd = cmds[i];
            scan_slot = slots[i];
            scan_go = 1'b1;
            tick(1);
            scan_go = 1'b0;
            tick(1);
            check(connect_mask, exps[i], "scan");
            scan_end = 1'b1;
            tick(1);
            scan_end = 1'b0;
            tick(1);
            check(connect_mask, 16'h0, "end");
        end
        // A none command replaces a live group scan with nothing
        scan_cmd = 2'h2;
        scan_go = 1'b1;
        tick(1);
        scan_cmd = 2'h0;
        tick(1);
        scan_go = 1'b0;
        tick(1);
        check(connect_mask, 16'h0, "none");
        widget_idx = 2'h1;
        for (int i = 0; i < 2; i++)
        begin
            move_widget = 1'b1;
            tick(1);
            move_widget = 1'b0;
            tick(1);
            check(widget_channel, i == 0 ? 2 : 0, "chan");
        end
    endtask

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial
    begin
        tick(20);
        rst_b = 1'b1;
        tick(3);
        check(guard_invalid, 1'b0, "reset");
        touch_cycle();
        resolution();
        settings();
        scans();
        complete_run();
    end

    // About 240 cycles are needed; 7000, some 29 times that, is a hang
    initial
    begin
        #175000;
        err_total++;
        complete_run();
    end
endmodule // tb_top
